// [rtl/flag_regs_consts.svh]
// Constants for the fault and event flag registers: offsets, bit positions, timing.
// Assumes a 10 MHz system clock shared with the control bus.
`ifndef FLAG_REGS_CONSTS_SVH
`define FLAG_REGS_CONSTS_SVH

`define FR_PAGE_MAIN 8'h00
`define FR_ADDR_BUTTON_CLR 7'h0E
`define FR_ADDR_DRV_STATUS 7'h5F
`define FR_ADDR_STICKY 7'h60
`define FR_ADDR_LIVE 7'h61

`define FR_BIT_SHORT_L 7
`define FR_BIT_SHORT_R 6
`define FR_BIT_SHORT_C 5
`define FR_BIT_COM_PWR 3
`define FR_BIT_BUTTON 3
`define FR_BIT_HEADSET 2
`define FR_BIT_GATE_L 1
`define FR_BIT_GATE_R 0

`define FR_REG_RESET 8'h00
`define FR_CLK_KHZ 10000
`define FR_IRQ_PULSE_US 2000
`define FR_IRQ_GAP_US 2000

`endif

// [rtl/flag_regs_pkg.sv]
// Types shared by the fault and event flag register logic.
// Assumes flag_regs_consts.svh supplies the numeric constants.
package flag_regs_pkg;

    typedef struct packed {
        logic short_left;   // Short on the left headphone driver.
        logic short_right;  // Short on the right headphone driver.
        logic short_common; // Short on the common headphone driver.
        logic common_power; // Common driver fully powered up.
        logic button;       // Headset button held.
        logic headset;      // Headset present.
        logic gate_left;    // Left record power below noise threshold.
        logic gate_right;   // Right record power below noise threshold.
    } detect_t;

    typedef struct packed {
        logic       req;  // One-cycle read request.
        logic [7:0] page; // Register page.
        logic [6:0] addr; // Register number.
    } read_req_t;

    typedef enum logic [1:0] {
        IRQ_IDLE,
        IRQ_HIGH,
        IRQ_LOW
    } irq_state_t;

endpackage

// [rtl/level_sync.sv]
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; no bus coherence is promised across bits.
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk, // System clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic [WIDTH-1:0] async_in, // Levels from another domain.
    output logic [WIDTH-1:0] sync_out // Levels safe to use on clk.
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) $error("level_sync: WIDTH must be at least 1.");
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // level_sync
`default_nettype wire

// [rtl/fault_and_event_flag_regs.sv]
// Fault and event flag registers: live driver status, sticky flags, real-time flags.
// Assumes detector levels arrive asynchronously and reads come on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "flag_regs_consts.svh"
module fault_and_event_flag_regs #(
    parameter int CLK_KHZ = `FR_CLK_KHZ,
    parameter int IRQ_PULSE_CYC = (`FR_IRQ_PULSE_US * CLK_KHZ) / 1000,
    parameter int IRQ_GAP_CYC = (`FR_IRQ_GAP_US * CLK_KHZ) / 1000
) (
    input wire logic clk, // System clock, 10 MHz.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire flag_regs_pkg::detect_t detect, // Raw detector levels.
    input wire flag_regs_pkg::read_req_t rd, // Register read request.
    input wire logic irq_continuous, // 1: pulse until sticky read; 0: one pulse.
    output logic [7:0] rd_data_q, // Read data, valid with rd_ack_q.
    output logic rd_ack_q, // One-cycle read answer.
    output logic irq_q // Interrupt output, active high.
);
    // Wide enough for any pulse or gap count that a parameter can hold.
    localparam int CNT_W = 32;
    localparam int DET_W = $bits(flag_regs_pkg::detect_t);

    flag_regs_pkg::detect_t det_s;
    flag_regs_pkg::detect_t det_prev_q;
    flag_regs_pkg::irq_state_t irq_state_q;
    flag_regs_pkg::irq_state_t irq_state_d;
    logic [7:0] sticky_q;
    logic [7:0] sticky_d;
    logic [7:0] sticky_set;
    logic [7:0] sticky_kept;
    logic button_hold_q;
    logic button_hold_d;
    logic [CNT_W-1:0] irq_cnt_q;
    logic [CNT_W-1:0] irq_cnt_d;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] pulse_load;
    logic [CNT_W-1:0] gap_load;
    logic [7:0] short_bits;
    logic [7:0] gate_bits;
    logic [7:0] edge_bits;
    logic [7:0] drv_status;
    logic [7:0] live_flags;
    logic [7:0] rd_mux;
    logic [7:0] rd_data_d;
    logic rd_ack_d;
    logic irq_d;
    logic hit_status;
    logic hit_sticky;
    logic hit_live;
    logic hit_button_clr;
    logic sticky_read;
    logic button_read;
    logic button_rise;
    logic headset_edge;
    logic new_event;
    logic irq_pending;
    logic irq_repeat;
    logic cnt_done;

    // A zero-length pulse or gap would leave the interrupt stuck in one state.
    initial begin
        if (CLK_KHZ < 1) begin
            $error("fault_and_event_flag_regs: CLK_KHZ must be at least 1.");
        end
        if (IRQ_PULSE_CYC < 1) begin
            $error("fault_and_event_flag_regs: IRQ_PULSE_CYC must be at least 1.");
        end
        if (IRQ_GAP_CYC < 1) begin
            $error("fault_and_event_flag_regs: IRQ_GAP_CYC must be at least 1.");
        end
        if (DET_W != 8) begin
            $error("fault_and_event_flag_regs: detector bundle must be one byte.");
        end
    end

    // Detector levels come from analog circuits on no clock of ours.
    level_sync #(
        .WIDTH(DET_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(detect),
        .sync_out(det_s)
    );

    // Puts one flag at its bit position in an otherwise clear byte.
    function automatic logic [7:0] place_bit(input logic v, input int pos);
        logic [7:0] r;
        r = 8'h00;
        r[pos[2:0]] = v;
        return r;
    endfunction

    // The three driver shorts share one layout in all three registers.
    function automatic logic [7:0] short_field(input flag_regs_pkg::detect_t d);
        logic [7:0] r;
        r = place_bit(d.short_left, `FR_BIT_SHORT_L);
        r = r | place_bit(d.short_right, `FR_BIT_SHORT_R);
        r = r | place_bit(d.short_common, `FR_BIT_SHORT_C);
        return r;
    endfunction

    // The two noise gates share one layout in the sticky and live registers.
    function automatic logic [7:0] gate_field(input flag_regs_pkg::detect_t d);
        logic [7:0] r;
        r = place_bit(d.gate_left, `FR_BIT_GATE_L);
        r = r | place_bit(d.gate_right, `FR_BIT_GATE_R);
        return r;
    endfunction

    // True when a request addresses the given register on the main page.
    function automatic logic reg_hit(
        input flag_regs_pkg::read_req_t r,
        input logic [6:0] a
    );
        return r.req && (r.page == `FR_PAGE_MAIN) && (r.addr == a);
    endfunction

    // Address decode of the main page registers this block owns or watches.
    assign hit_status = reg_hit(rd, `FR_ADDR_DRV_STATUS);
    assign hit_sticky = reg_hit(rd, `FR_ADDR_STICKY);
    assign hit_live = reg_hit(rd, `FR_ADDR_LIVE);
    assign hit_button_clr = reg_hit(rd, `FR_ADDR_BUTTON_CLR);
    assign sticky_read = hit_sticky;
    assign button_read = hit_button_clr;

    assign short_bits = short_field(det_s);
    assign gate_bits = gate_field(det_s);
    assign button_rise = det_s.button && !det_prev_q.button;
    assign headset_edge = det_s.headset ^ det_prev_q.headset;
    assign edge_bits = place_bit(button_rise, `FR_BIT_BUTTON)
        | place_bit(headset_edge, `FR_BIT_HEADSET);

    // Reserved bits are left at zero by construction.
    assign drv_status = short_bits
        | place_bit(det_s.common_power, `FR_BIT_COM_PWR);

    // Shorts and noise gates set while present; the headset sets on either edge.
    assign sticky_set = short_bits | gate_bits | edge_bits;

    // A set in the cycle of the clearing read wins, so no event is lost.
    assign sticky_kept = sticky_read ? `FR_REG_RESET : sticky_q;
    assign sticky_d = sticky_kept | sticky_set;

    // A new press in the cycle of the clearing read wins for the same reason.
    assign button_hold_d = button_rise || (button_hold_q && !button_read);

    assign live_flags = short_bits
        | place_bit(button_hold_q, `FR_BIT_BUTTON)
        | place_bit(det_s.headset, `FR_BIT_HEADSET)
        | gate_bits;

    assign rd_mux = hit_status ? drv_status
        : hit_sticky ? sticky_q
        : hit_live ? live_flags
        : `FR_REG_RESET;
    assign rd_data_d = rd.req ? rd_mux : `FR_REG_RESET;
    assign rd_ack_d = rd.req;

    // An event is new when a sticky bit goes from clear to set.
    assign new_event = |(sticky_set & ~sticky_q);
    assign irq_pending = sticky_d != `FR_REG_RESET;
    assign irq_repeat = irq_continuous && irq_pending;
    assign cnt_done = irq_cnt_q == '0;
    assign cnt_next = irq_cnt_q - CNT_W'(1);
    assign pulse_load = CNT_W'(IRQ_PULSE_CYC - 1);
    assign gap_load = CNT_W'(IRQ_GAP_CYC - 1);

    // In continuous mode the pulse train runs while any sticky bit is pending,
    // so the sticky read is what stops it; single mode gives one pulse per new event seen while idle.
    // Events that arrive during a pulse or gap do not restart it, which keeps
    // the pulse width fixed for whatever edge detector sits on the pin.
    always_comb begin
        irq_state_d = irq_state_q;
        irq_cnt_d = irq_cnt_q;
        unique case (irq_state_q)
            flag_regs_pkg::IRQ_IDLE: begin
                if (new_event) begin
                    irq_state_d = flag_regs_pkg::IRQ_HIGH;
                    irq_cnt_d = pulse_load;
                end
            end
            flag_regs_pkg::IRQ_HIGH: begin
                if (!cnt_done) begin
                    irq_cnt_d = cnt_next;
                end else begin
                    irq_state_d = flag_regs_pkg::IRQ_LOW;
                    irq_cnt_d = gap_load;
                end
            end
            flag_regs_pkg::IRQ_LOW: begin
                if (!cnt_done) begin
                    irq_cnt_d = cnt_next;
                end else if (irq_repeat) begin
                    irq_state_d = flag_regs_pkg::IRQ_HIGH;
                    irq_cnt_d = pulse_load;
                end else begin
                    irq_state_d = flag_regs_pkg::IRQ_IDLE;
                end
            end
            default: begin
                // The fourth code of the state register is never entered; recover.
                irq_state_d = flag_regs_pkg::IRQ_IDLE;
                irq_cnt_d = '0;
            end
        endcase
    end

    assign irq_d = irq_state_d == flag_regs_pkg::IRQ_HIGH;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            det_prev_q <= '0;
        end else begin
            det_prev_q <= det_s;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sticky_q <= `FR_REG_RESET;
        end else begin
            sticky_q <= sticky_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            button_hold_q <= 1'b0;
        end else begin
            button_hold_q <= button_hold_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_state_q <= flag_regs_pkg::IRQ_IDLE;
        end else begin
            irq_state_q <= irq_state_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_cnt_q <= '0;
        end else begin
            irq_cnt_q <= irq_cnt_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_q <= `FR_REG_RESET;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= rd_ack_d;
        end
    end

    // Registered from the next state so the pin rises on the same edge as the flag.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end
endmodule // fault_and_event_flag_regs
`default_nettype wire

// [bench/fault_and_event_flag_regs_monitor.sv]
// Checker for the flag registers: read data against held detector levels, interrupt width.
// Assumes detectors stay put for several cycles around each read.
`timescale 1ns/1ps
`default_nettype none
module fault_and_event_flag_regs_monitor #(
    parameter int IRQ_PULSE_CYC = 4
) (
    input wire logic clk, // System clock.
    input wire logic sys_rst, // Asynchronous reset.
    input wire flag_regs_pkg::detect_t detect, // Detector levels.
    input wire flag_regs_pkg::read_req_t rd, // Read request.
    input wire logic [7:0] rd_data_q, // Read data.
    input wire logic irq_q // Interrupt.
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic r0e = rd.req && rd.page == 8'h00 && rd.addr == 7'h0E;
    wire logic r5f = rd.req && rd.page == 8'h00 && rd.addr == 7'h5F;
    wire logic r60 = rd.req && rd.page == 8'h00 && rd.addr == 7'h60;
    wire logic r61 = rd.req && rd.page == 8'h00 && rd.addr == 7'h61;
    logic [15:0] hi_q;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst) hi_q <= 16'h0000;
        else hi_q <= irq_q ? hi_q + 16'h0001 : 16'h0000;
    sequence s_quiet; $stable(detect)[*4]; endsequence
    sequence s_press; $rose(detect.button) ##1 (!r0e)[*3]; endsequence
    property p_status; s_quiet ##0 r5f ##1 $stable(detect)
        |-> rd_data_q == {detect[7:5], 1'b0, detect[4], 3'b000}; endproperty
    property p_live; s_quiet ##0 r61 ##1 $stable(detect)
        |-> {rd_data_q[7:4], rd_data_q[2:0]} == {detect[7:5], 1'b0, detect[2:0]}; endproperty
    property p_level; s_quiet ##0 r60 ##1 $stable(detect)
        |-> (rd_data_q & detect & 8'hE3) == (detect & 8'hE3) && !rd_data_q[4]; endproperty
    property p_headset; $changed(detect.headset) ##1 (!r60)[*7] ##1 r60 |=> rd_data_q[2]; endproperty
    property p_hold; s_press ##1 r61 |=> rd_data_q[3]; endproperty
    property p_hold_clr; (!detect.button)[*4] ##0 r0e ##2 r61 |=> !rd_data_q[3]; endproperty
    property p_clear; (detect == 8'h00)[*5] ##0 r60 ##2 r60 |=> rd_data_q == 8'h00; endproperty
    property p_width; $fell(irq_q) |-> hi_q == IRQ_PULSE_CYC; endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    a_live: assert property (p_live) else $error("live read wrong");
    a_level: assert property (p_level) else $error("sticky level lost");
    a_headset: assert property (p_headset) else $error("headset edge lost");
    a_hold: assert property (p_hold) else $error("press not held");
    a_hold_clr: assert property (p_hold_clr) else $error("press not cleared");
    a_clear: assert property (p_clear) else $error("sticky not cleared");
    a_width: assert property (p_width) else $error("pulse width wrong");
endmodule // fault_and_event_flag_regs_monitor
bind fault_and_event_flag_regs fault_and_event_flag_regs_monitor #(
    .IRQ_PULSE_CYC(IRQ_PULSE_CYC)
) i_fault_and_event_flag_regs_monitor (.clk(clk), .sys_rst(sys_rst), .detect(detect),
    .rd(rd), .rd_data_q(rd_data_q), .irq_q(irq_q));
`default_nettype wire

// [bench/flag_host_model.sv]
// Host model: issues single register reads and returns the answer strobe with the data.
// Assumes it shares clk with the block and each read is started at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module flag_host_model (
    input wire logic clk, // System clock.
    input wire logic [7:0] rd_data_q, // Read data.
    input wire logic rd_ack_q, // Read answer.
    output var flag_regs_pkg::read_req_t rd // Read request.
);
    initial rd = '0;
    // The host only reads, so reserved status bits are never written.
    // A read of the sticky register is also the interrupt acknowledge.
    task automatic read(input logic [7:0] pg, input logic [6:0] a, output logic [8:0] r);
        rd <= '{1'b1, pg, a};
        @(posedge clk);
        rd.req <= 1'b0;
        @(posedge clk);
        r = {rd_ack_q, rd_data_q};
    endtask
endmodule // flag_host_model
`default_nettype wire

// [bench/fault_and_event_flag_regs_test.sv]
// Testbench for the flag registers: random detector levels, reads, interrupt trains.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module fault_and_event_flag_regs_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    flag_regs_pkg::detect_t detect = '0;
    logic irq_continuous = 1'b0;
    flag_regs_pkg::read_req_t rd;
    logic [7:0] rd_data_q, d, e, p = 8'h00;
    logic rd_ack_q, irq_q, hold = 1'b0;
    logic [8:0] r;
    int fail_count = 0, n_checks = 0, seed = 32'h48d3d15c, c;
    always #50 clk = ~clk;
    fault_and_event_flag_regs #(.IRQ_PULSE_CYC(4), .IRQ_GAP_CYC(3)) i_fault_and_event_flag_regs (
        .clk(clk), .sys_rst(sys_rst), .detect(detect), .rd(rd), .irq_continuous(irq_continuous),
        .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q), .irq_q(irq_q));
    flag_host_model i_flag_host_model (.clk(clk), .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q),
        .rd(rd));
    function automatic logic [7:0] lvl(input logic [7:0] x);
        return x & 8'hE3;
    endfunction
    task automatic check(input string n, input logic [8:0] s, input logic [8:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdc(input string n, input logic [6:0] a, input logic [7:0] e, input logic [7:0] pg);
        i_flag_host_model.read(pg, a, r);
        check(n, r, {1'b1, e});
    endtask
    task automatic count(input int n);
        logic l;
        l = irq_q;
        c = 0;
        repeat (n) begin
            @(posedge clk);
            if (irq_q === 1'b1 && l !== 1'b1) c++;
            l = irq_q;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #(100 * 5000);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 30; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            detect <= d;
            irq_continuous <= d[4];
            hold = hold | (d[3] & ~p[3]);
            repeat (4) @(posedge clk);
            rdc("live", 7'h61, {d[7:5], 1'b0, hold, d[2:0]}, 8'h00);
            rdc("status", 7'h5F, {d[7:5], 1'b0, d[4], 3'b000}, 8'h00);
            e = lvl(p) | lvl(d) | {4'h0, d[3] & ~p[3], d[2] ^ p[2], 2'b00};
            rdc("sticky", 7'h60, e, 8'h00);
            rdc("sticky2", 7'h60, lvl(d), 8'h00);
            if (d[0]) begin
                rdc("button_clr", 7'h0E, 8'h00, 8'h00);
                hold = 1'b0;
                rdc("live2", 7'h61, {d[7:5], 2'b00, d[2:0]}, 8'h00);
            end
            rdc("unmapped", 7'h60, 8'h00, d | 8'h01);
            p = d;
        end
        detect <= '0;
        irq_continuous <= 1'b1;
        repeat (12) @(posedge clk);
        i_flag_host_model.read(8'h00, 7'h60, r);
        rdc("quiet", 7'h60, 8'h00, 8'h00);
        repeat (10) @(posedge clk);
        detect <= 8'h04;
        count(30);
        check("irq_train", {8'h00, c >= 2}, 9'h001);
        i_flag_host_model.read(8'h00, 7'h60, r);
        count(30);
        check("irq_acked", 9'(c), 9'h000);
        irq_continuous <= 1'b0;
        detect <= '0;
        count(30);
        check("irq_single", 9'(c), 9'h001);
        summarize();
    end
endmodule // fault_and_event_flag_regs_test
`default_nettype wire
